// ### common/dma_pkg.sv
package dma_pkg;
  localparam int NCH = 16;
  localparam int NCH_HALF = 8;
  localparam int CHW = 4;
  localparam int AW = 12;
  // Byte offsets; channel c (0-7 transmit, 8-15 receive) sits at base + 4*c.
  localparam logic [AW-1:0] HEAD_BASE = 12'h000;
  localparam logic [AW-1:0] CP_BASE = 12'h040;
  localparam logic [AW-1:0] TX_RAW_OFF = 12'h080;
  localparam logic [AW-1:0] RX_RAW_OFF = 12'h084;
  localparam logic [AW-1:0] TX_EN_SET_OFF = 12'h088;
  localparam logic [AW-1:0] TX_EN_CLR_OFF = 12'h08c;
  localparam logic [AW-1:0] RX_EN_SET_OFF = 12'h090;
  localparam logic [AW-1:0] RX_EN_CLR_OFF = 12'h094;
  localparam logic [AW-1:0] TX_MASKED_OFF = 12'h098;
  localparam logic [AW-1:0] RX_MASKED_OFF = 12'h09c;
  localparam logic [AW-1:0] BANK_SPAN = 12'h040;
  // Descriptor word offsets in bytes.
  localparam logic [31:0] W1_OFF = 32'h0000_0004;
  localparam logic [31:0] W2_OFF = 32'h0000_0008;
  localparam logic [31:0] W3_OFF = 32'h0000_000c;
  // Flag word masks.
  localparam logic [31:0] SOP_MASK = 32'h8000_0000;
  localparam logic [31:0] EOP_MASK = 32'h4000_0000;
  localparam logic [31:0] OWNER_MASK = 32'h2000_0000;
  localparam logic [31:0] EOQ_MASK = 32'h1000_0000;
  localparam logic [31:0] CRC_SUPPLIED_MASK = 32'h0400_0000;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  typedef enum logic [3:0] {S_IDLE, S_RD1, S_RD2, S_RD3, S_FRAG, S_RDNXT, S_WEOQ, S_WSOP} eng_state_t;

  function automatic logic [CHW-1:0] chan_of(input logic [AW-1:0] a);
    return a[CHW+1:2];
  endfunction

  function automatic logic [15:0] hi_half(input logic [31:0] w);
    return w[31:16];
  endfunction

  function automatic logic [15:0] lo_half(input logic [31:0] w);
    return w[15:0];
  endfunction
endpackage

// ### logic/desc_queue_dma.sv
// Function
// - Sixteen completion pointers, eight transmit, eight receive.
// - Pointer read returns last finished descriptor.
// - Differing software pointer keeps interrupt asserted.
// - Matching pointer write acknowledges the interrupt.
// - Enable-set bit gates each channel interrupt.
// - Raw interrupt state readable regardless of enables.
// - Word 0 links; zero ends queue.
// - Zero link is last; link never written.
// - Patched link followed unless null already read.
// - Buffer address used, never modified.
// - Offset skips leading bytes, never modified.
// - Offset applied only on start descriptors.
// - Buffer length counts data bytes, untouched.
// - Packet length read only at start.
// - Word 2: offset high, length low.
// - Word 3: flags high, packet length low.
// - Ownership cleared after packet; start only.
// - Null link at end sets end-of-queue, halts.
// - Clear crc flag means append crc.
//
// Local design decisions: register access over AHB-Lite and the register addresses.
module desc_queue_dma (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Descriptor memory master
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // Fragment hand-off to the data path
  output logic frag_valid,
  output logic [dma_pkg::CHW-1:0] frag_chan,
  output logic [31:0] frag_addr,
  output logic [15:0] frag_len,
  output logic [15:0] frag_pkt_len,
  output logic frag_sop,
  output logic frag_eop,
  output logic frag_crc_gen,
  input wire logic frag_done,
  // Interrupt lines
  output logic tx_irq,
  output logic rx_irq
);
  import dma_pkg::*;

  logic hreadyout_ff, hresp_ff, wr_pend_ff, tx_irq_ff, rx_irq_ff, mem_req_ff, mem_we_ff;
  logic [AW-1:0] wr_addr_ff, ra;
  logic [31:0] cur_ff [NCH], hw_cp_ff [NCH], sw_cp_ff [NCH];
  logic [NCH-1:0] active_ff, enable_ff, raw_ff, masked_ff;
  eng_state_t state_ff;
  logic [CHW-1:0] ch_ff, last_ff, frag_chan_ff, pick_idx;
  logic [31:0] desc_ff, buf_ff, len_word_ff, flags_ff, sop_desc_ff, sop_flags_ff, next_ff;
  logic [31:0] hrdata_ff, mem_addr_ff, mem_wdata_ff, frag_addr_ff;
  logic frag_valid_ff, frag_sop_ff, frag_eop_ff, frag_crc_gen_ff;
  logic [15:0] frag_len_ff, frag_pkt_len_ff;
  logic pick_valid, addr_phase, wr_now, retire, halt;

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign mem_req = mem_req_ff;
  assign mem_we = mem_we_ff;
  assign mem_addr = mem_addr_ff;
  assign mem_wdata = mem_wdata_ff;
  assign frag_valid = frag_valid_ff;
  assign frag_chan = frag_chan_ff;
  assign frag_addr = frag_addr_ff;
  assign frag_len = frag_len_ff;
  assign frag_pkt_len = frag_pkt_len_ff;
  assign frag_sop = frag_sop_ff;
  assign frag_eop = frag_eop_ff;
  assign frag_crc_gen = frag_crc_gen_ff;
  assign tx_irq = tx_irq_ff;
  assign rx_irq = rx_irq_ff;

  // Only whole-word transfers are issued, so hsize is not decoded.
  assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;
  assign ra = haddr[AW-1:0];
  assign wr_now = wr_pend_ff;

  function automatic logic in_bank(input logic [AW-1:0] a, input logic [AW-1:0] base);
    return a >= base && a < base + BANK_SPAN && a[1:0] == 2'h0;
  endfunction

  // Read mux is sampled in the address phase and held for the data phase.
  // A read right after a write to the same register sees the old value.
  function automatic logic [31:0] read_mux(input logic [AW-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (in_bank(a, HEAD_BASE)) begin
      v = cur_ff[chan_of(a)];
    end else if (in_bank(a, CP_BASE)) begin
      v = hw_cp_ff[chan_of(a)];
    end else if (a == TX_RAW_OFF) begin
      v = {24'h00_0000, raw_ff[NCH_HALF-1:0]};
    end else if (a == RX_RAW_OFF) begin
      v = {24'h00_0000, raw_ff[NCH-1:NCH_HALF]};
    end else if (a == TX_EN_SET_OFF || a == TX_EN_CLR_OFF) begin
      v = {24'h00_0000, enable_ff[NCH_HALF-1:0]};
    end else if (a == RX_EN_SET_OFF || a == RX_EN_CLR_OFF) begin
      v = {24'h00_0000, enable_ff[NCH-1:NCH_HALF]};
    end else if (a == TX_MASKED_OFF) begin
      v = {24'h00_0000, masked_ff[NCH_HALF-1:0]};
    end else if (a == RX_MASKED_OFF) begin
      v = {24'h00_0000, masked_ff[NCH-1:NCH_HALF]};
    end
    return v;
  endfunction

  // Bus slave: zero wait states, always OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_ff <= ra;
        hrdata_ff <= hwrite ? 32'h0000_0000 : read_mux(ra);
      end
    end
  end

  // Software completion pointers; the written value is only a record, never a clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int c = 0; c < NCH; c++) begin
        sw_cp_ff[c] <= 32'h0000_0000;
      end
    end else if (wr_now && in_bank(wr_addr_ff, CP_BASE)) begin
      sw_cp_ff[chan_of(wr_addr_ff)] <= hwdata;
    end
  end

  // Interrupt enables: set and clear by separate write-one registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_ff <= '0;
    end else if (wr_now) begin
      if (wr_addr_ff == TX_EN_SET_OFF) begin
        enable_ff[NCH_HALF-1:0] <= enable_ff[NCH_HALF-1:0] | hwdata[NCH_HALF-1:0];
      end else if (wr_addr_ff == TX_EN_CLR_OFF) begin
        enable_ff[NCH_HALF-1:0] <= enable_ff[NCH_HALF-1:0] & ~hwdata[NCH_HALF-1:0];
      end else if (wr_addr_ff == RX_EN_SET_OFF) begin
        enable_ff[NCH-1:NCH_HALF] <= enable_ff[NCH-1:NCH_HALF] | hwdata[NCH_HALF-1:0];
      end else if (wr_addr_ff == RX_EN_CLR_OFF) begin
        enable_ff[NCH-1:NCH_HALF] <= enable_ff[NCH-1:NCH_HALF] & ~hwdata[NCH_HALF-1:0];
      end
    end
  end

  irq_gate #(.N(NCH)) u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .hw_cp(hw_cp_ff),
    .sw_cp(sw_cp_ff),
    .enable(enable_ff),
    .raw_ff(raw_ff),
    .masked_ff(masked_ff),
    .tx_irq_ff(tx_irq_ff),
    .rx_irq_ff(rx_irq_ff)
  );

  rr_pick #(.N(NCH), .W(CHW)) u_pick (
    .req(active_ff),
    .last(last_ff),
    .valid(pick_valid),
    .idx(pick_idx)
  );

  // Packet finished: ownership write-back acknowledged.
  assign retire = state_ff == S_WSOP && mem_ack;
  // Channel stops without finishing a packet: start descriptor not owned, or null link before the end of packet.
  assign halt = (state_ff == S_RD3 && mem_ack && (mem_rdata & SOP_MASK) != 0 && (mem_rdata & OWNER_MASK) == 0)
    || (state_ff == S_RDNXT && mem_ack && (flags_ff & EOP_MASK) == 0 && mem_rdata == 32'h0000_0000);

  // Channel state: head writes start idle channels, the engine advances and stops them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_ff <= '0;
      for (int c = 0; c < NCH; c++) begin
        cur_ff[c] <= 32'h0000_0000;
        hw_cp_ff[c] <= 32'h0000_0000;
      end
    end else begin
      // A head write to a busy channel is ignored; appending is done by patching the link.
      if (wr_now && in_bank(wr_addr_ff, HEAD_BASE) && !active_ff[chan_of(wr_addr_ff)] && hwdata != 32'h0000_0000) begin
        cur_ff[chan_of(wr_addr_ff)] <= hwdata;
        active_ff[chan_of(wr_addr_ff)] <= 1'b1;
      end
      if (retire) begin
        hw_cp_ff[ch_ff] <= desc_ff;
        cur_ff[ch_ff] <= next_ff;
        active_ff[ch_ff] <= next_ff != 32'h0000_0000;
      end else if (halt) begin
        cur_ff[ch_ff] <= 32'h0000_0000;
        active_ff[ch_ff] <= 1'b0;
      end else if (state_ff == S_RDNXT && mem_ack) begin
        cur_ff[ch_ff] <= mem_rdata;
      end
    end
  end

  // Descriptor engine; a channel keeps the engine until its packet is finished or the channel halts.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= S_IDLE;
      ch_ff <= '0;
      last_ff <= '0;
      desc_ff <= 32'h0000_0000;
      buf_ff <= 32'h0000_0000;
      len_word_ff <= 32'h0000_0000;
      flags_ff <= 32'h0000_0000;
      sop_desc_ff <= 32'h0000_0000;
      sop_flags_ff <= 32'h0000_0000;
      next_ff <= 32'h0000_0000;
      mem_req_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_addr_ff <= 32'h0000_0000;
      mem_wdata_ff <= 32'h0000_0000;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (pick_valid) begin
            ch_ff <= pick_idx;
            last_ff <= pick_idx;
            desc_ff <= cur_ff[pick_idx];
            mem_req_ff <= 1'b1;
            mem_we_ff <= 1'b0;
            mem_addr_ff <= cur_ff[pick_idx] + W1_OFF;
            state_ff <= S_RD1;
          end
        end
        S_RD1: begin
          if (mem_ack) begin
            buf_ff <= mem_rdata;
            mem_addr_ff <= desc_ff + W2_OFF;
            state_ff <= S_RD2;
          end
        end
        S_RD2: begin
          if (mem_ack) begin
            len_word_ff <= mem_rdata;
            mem_addr_ff <= desc_ff + W3_OFF;
            state_ff <= S_RD3;
          end
        end
        S_RD3: begin
          if (mem_ack) begin
            flags_ff <= mem_rdata;
            mem_req_ff <= 1'b0;
            if ((mem_rdata & SOP_MASK) != 0) begin
              sop_desc_ff <= desc_ff;
              sop_flags_ff <= mem_rdata;
            end
            state_ff <= halt ? S_IDLE : S_FRAG;
          end
        end
        S_FRAG: begin
          if (frag_done) begin
            // The link is read only now, so a patch made during the transfer is seen.
            mem_req_ff <= 1'b1;
            mem_addr_ff <= desc_ff;
            state_ff <= S_RDNXT;
          end
        end
        S_RDNXT: begin
          if (mem_ack) begin
            next_ff <= mem_rdata;
            if ((flags_ff & EOP_MASK) != 0) begin
              mem_we_ff <= 1'b1;
              if (mem_rdata == 32'h0000_0000) begin
                mem_addr_ff <= desc_ff + W3_OFF;
                mem_wdata_ff <= (flags_ff | EOQ_MASK) & ~(sop_desc_ff == desc_ff ? OWNER_MASK : '0);
                state_ff <= S_WEOQ;
              end else begin
                mem_addr_ff <= sop_desc_ff + W3_OFF;
                mem_wdata_ff <= sop_flags_ff & ~OWNER_MASK;
                state_ff <= S_WSOP;
              end
            end else if (halt) begin
              mem_req_ff <= 1'b0;
              state_ff <= S_IDLE;
            end else begin
              desc_ff <= mem_rdata;
              mem_addr_ff <= mem_rdata + W1_OFF;
              state_ff <= S_RD1;
            end
          end
        end
        S_WEOQ: begin
          if (mem_ack) begin
            // A single-descriptor packet must keep the end-of-queue mark in its flag word.
            mem_addr_ff <= sop_desc_ff + W3_OFF;
            mem_wdata_ff <= (sop_flags_ff & ~OWNER_MASK) | (sop_desc_ff == desc_ff ? EOQ_MASK : 32'h0000_0000);
            state_ff <= S_WSOP;
          end
        end
        S_WSOP: begin
          if (mem_ack) begin
            mem_req_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            state_ff <= S_IDLE;
          end
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end

  // Fragment presented to the data path; offset, packet length and crc mode come from the start descriptor.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frag_valid_ff <= 1'b0;
      frag_chan_ff <= '0;
      frag_addr_ff <= 32'h0000_0000;
      frag_len_ff <= 16'h0000;
      frag_pkt_len_ff <= 16'h0000;
      frag_sop_ff <= 1'b0;
      frag_eop_ff <= 1'b0;
      frag_crc_gen_ff <= 1'b0;
    end else if (state_ff == S_RD3 && mem_ack && !halt) begin
      frag_valid_ff <= 1'b1;
      frag_chan_ff <= ch_ff;
      frag_len_ff <= lo_half(len_word_ff);
      frag_sop_ff <= (mem_rdata & SOP_MASK) != 0;
      frag_eop_ff <= (mem_rdata & EOP_MASK) != 0;
      if ((mem_rdata & SOP_MASK) != 0) begin
        frag_addr_ff <= buf_ff + {16'h0000, hi_half(len_word_ff)};
        frag_pkt_len_ff <= lo_half(mem_rdata);
        frag_crc_gen_ff <= (mem_rdata & CRC_SUPPLIED_MASK) == 0;
      end else begin
        frag_addr_ff <= buf_ff;
      end
    end else if (state_ff == S_FRAG && frag_done) begin
      frag_valid_ff <= 1'b0;
    end
  end
endmodule // desc_queue_dma

// ### logic/irq_gate.sv
// Per-channel interrupt state: pending while hardware and software completion pointers differ.
module irq_gate #(
  parameter int N = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Completion pointers and enables
  input wire logic [31:0] hw_cp [N],
  input wire logic [31:0] sw_cp [N],
  input wire logic [N-1:0] enable,
  // State
  output logic [N-1:0] raw_ff,
  output logic [N-1:0] masked_ff,
  output logic tx_irq_ff,
  output logic rx_irq_ff
);
  logic [N-1:0] nxt_raw;

  always_comb begin
    for (int c = 0; c < N; c++) begin
      nxt_raw[c] = hw_cp[c] != sw_cp[c];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_ff <= '0;
      masked_ff <= '0;
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      raw_ff <= nxt_raw;
      masked_ff <= nxt_raw & enable;
      tx_irq_ff <= |(nxt_raw[N/2-1:0] & enable[N/2-1:0]);
      rx_irq_ff <= |(nxt_raw[N-1:N/2] & enable[N-1:N/2]);
    end
  end
endmodule // irq_gate

// ### logic/rr_pick.sv
// Round-robin choice among active channels, starting just after the last grant.
module rr_pick #(
  parameter int N = 16,
  parameter int W = 4
) (
  // Requests
  input wire logic [N-1:0] req,
  input wire logic [W-1:0] last,
  // Choice
  output logic valid,
  output logic [W-1:0] idx
);
  always_comb begin
    logic [W-1:0] cand;
    cand = '0;
    valid = 1'b0;
    idx = '0;
    for (int k = 1; k <= N; k++) begin
      cand = W'((int'(last) + k) % N);
      if (!valid && req[cand]) begin
        valid = 1'b1;
        idx = cand;
      end
    end
  end
endmodule // rr_pick

// ### sim/desc_mem.sv
module desc_mem (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Descriptor memory port
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] m [256];
  logic [1:0] wait_ff;
  logic slow_ff;

  // Answers alternate between prompt and two waits, so the engine never sees one fixed latency.
  // Outside an answer the read data toggles, because a real memory leaves the bus undefined there.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'h0;
      wait_ff <= 2'h0;
      slow_ff <= 1'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && wait_ff == {slow_ff, 1'h0}) begin
      mem_ack <= 1'h1;
      wait_ff <= 2'h0;
      slow_ff <= ~slow_ff;
      if (mem_we)
        m[mem_addr[9:2]] <= mem_wdata;
      else
        mem_rdata <= m[mem_addr[9:2]];
    end else begin
      mem_ack <= 1'h0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule // desc_mem

// ### sim/desc_queue_dma_checker.sv
module desc_queue_dma_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Descriptor memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  // Fragments and interrupts
  input wire logic frag_valid,
  input wire logic [31:0] frag_addr,
  input wire logic [15:0] frag_len,
  input wire logic frag_done,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  import dma_pkg::*;
  logic wr_ff;
  logic [11:0] wa_ff;
  logic [15:0] en_ff;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Enable bits are rebuilt from bus writes, so interrupt gating can be judged at the pins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'h0;
      wa_ff <= 12'h0;
      en_ff <= 16'h0;
    end else if (hready) begin
      wr_ff <= hsel && hwrite && htrans == HTRANS_NONSEQ;
      wa_ff <= haddr[11:0];
      if (wr_ff) begin
        case (wa_ff)
          TX_EN_SET_OFF: en_ff[7:0] <= en_ff[7:0] | hwdata[7:0];
          TX_EN_CLR_OFF: en_ff[7:0] <= en_ff[7:0] & ~hwdata[7:0];
          RX_EN_SET_OFF: en_ff[15:8] <= en_ff[15:8] | hwdata[7:0];
          RX_EN_CLR_OFF: en_ff[15:8] <= en_ff[15:8] & ~hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  sequence link_fetch_s;
    !frag_valid && mem_req && !mem_we;
  endsequence

  hready_high_a: assert property (hreadyout)
    else $error("slave inserted a wait state");
  resp_okay_a: assert property (!hresp)
    else $error("slave answered with an error");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
    else $error("memory request changed before its answer");
  frag_hold_a: assert property (frag_valid && !frag_done |=> frag_valid && $stable(frag_addr) && $stable(frag_len))
    else $error("fragment changed before it was taken");
  link_fetch_a: assert property (frag_valid && frag_done |=> link_fetch_s)
    else $error("link word not fetched after the fragment");
  owner_clear_a: assert property (mem_req && mem_we && mem_wdata[31] |-> !mem_wdata[29])
    else $error("start descriptor written back still owned");
  flag_keep_a: assert property (mem_req && mem_we |-> mem_wdata[31] || mem_wdata[30])
    else $error("write lost the packet flags");
  tx_gate_a: assert property ((en_ff[7:0] == 8'h0) [*3] |-> !tx_irq)
    else $error("transmit interrupt without enable");
  rx_gate_a: assert property ((en_ff[15:8] == 8'h0) [*3] |-> !rx_irq)
    else $error("receive interrupt without enable");
endmodule // desc_queue_dma_checker

bind desc_queue_dma desc_queue_dma_checker desc_queue_dma_checker_i (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
  .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
  .frag_valid, .frag_addr, .frag_len, .frag_done, .tx_irq, .rx_irq
);

// ### sim/desc_queue_dma_tb.sv
module desc_queue_dma_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dma_pkg::*;
  localparam logic [31:0] D0 = 32'h100, D1 = 32'h110, D2 = 32'h120, D3 = 32'h130, D4 = 32'h140;
  localparam logic [15:0] FS = SOP_MASK[31:16], FE = EOP_MASK[31:16], FO = OWNER_MASK[31:16];
  localparam logic [15:0] FQ = EOQ_MASK[31:16], FC = CRC_SUPPLIED_MASK[31:16];
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_req, mem_we, mem_ack;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, mem_addr, mem_wdata, mem_rdata, frag_addr, q;
  logic [3:0] frag_chan;
  logic [15:0] frag_len, frag_pkt_len;
  logic frag_valid, frag_sop, frag_eop, frag_crc_gen, tx_irq, rx_irq;
  logic frag_done = 1'h0;
  logic [1:0] fcnt = 2'h0;
  int num_errors = 0;
  int checks = 0;

  desc_queue_dma desc_queue_dma_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .frag_valid, .frag_chan, .frag_addr, .frag_len, .frag_pkt_len, .frag_sop, .frag_eop,
    .frag_crc_gen, .frag_done, .tx_irq, .rx_irq);
  desc_mem desc_mem_i (.hclk, .hresetn, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end

  // The data path stalls three cycles on every fragment.
  always @(posedge hclk) begin
    fcnt <= (frag_valid && !frag_done) ? fcnt + 2'h1 : 2'h0;
    frag_done <= frag_valid && !frag_done && fcnt == 2'h2;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    q = hrdata;
  endtask

  // Interrupt state lags a register write by one cycle, so writes wait before anyone looks.
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
    repeat (3) @(posedge hclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    bus(1'h0, a, 32'h0);
    chk(n, q, e);
  endtask

  task automatic poll(input logic [11:0] a, input logic [31:0] e, input string n);
    for (int i = 0; i < 60; i++) begin
      bus(1'h0, a, 32'h0);
      if (q === e)
        break;
    end
    chk(n, q, e);
  endtask

  task automatic put(input logic [31:0] a, nx, b, input logic [15:0] o, l, f, p);
    desc_mem_i.m[a / 4] = nx;
    desc_mem_i.m[a / 4 + 1] = b;
    desc_mem_i.m[a / 4 + 2] = {o, l};
    desc_mem_i.m[a / 4 + 3] = {f, p};
  endtask

  task automatic frag(input logic [31:0] a, input logic [15:0] l, p, input logic [6:0] f);
    while (!frag_valid) @(negedge hclk);
    chk("frag_addr", frag_addr, a);
    chk("frag_lens", {frag_len, frag_pkt_len}, {l, p});
    chk("frag_flags", {25'h0, frag_sop, frag_eop, frag_crc_gen, frag_chan}, {25'h0, f});
    while (frag_valid) @(negedge hclk);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    results;
  end

  initial begin
    hresetn = 1'h0;
    hsel = 1'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    for (int c = 0; c < NCH; c++)
      bus(1'h1, HEAD_BASE + 12'(4 * c), 32'h0);
    rd(CP_BASE, 32'h0, "cp_reset");
    rd(TX_RAW_OFF, 32'h0, "tx_raw_reset");
    wr(12'h0fc, 32'hffff_ffff);
    rd(12'h0fc, 32'h0, "unmapped");
    $display("test reset done");
    put(D0, 32'h0, 32'h8000, 16'h3, 16'h20, FS | FE | FO, 16'h20);
    wr(TX_EN_SET_OFF, 32'h1);
    wr(HEAD_BASE, D0);
    frag(32'h8003, 16'h20, 16'h20, 7'h70);
    poll(CP_BASE, D0, "cp_tx0");
    chk("d0_flags", desc_mem_i.m[D0 / 4 + 3], {FS | FE | FQ, 16'h20});
    chk("d0_link", desc_mem_i.m[D0 / 4], 32'h0);
    chk("d0_buf", desc_mem_i.m[D0 / 4 + 1], 32'h8000);
    chk("d0_len", desc_mem_i.m[D0 / 4 + 2], 32'h0003_0020);
    repeat (3) @(posedge hclk);
    chk("tx_irq", {31'h0, tx_irq}, 32'h1);
    rd(TX_RAW_OFF, 32'h1, "tx_raw");
    wr(CP_BASE, D1);
    chk("tx_irq_held", {31'h0, tx_irq}, 32'h1);
    wr(CP_BASE, D0);
    chk("tx_irq_ack", {31'h0, tx_irq}, 32'h0);
    rd(TX_RAW_OFF, 32'h0, "tx_raw_ack");
    $display("test single packet done");
    put(D1, D2, 32'h9000, 16'h5, 16'h10, FS | FO | FC, 16'h30);
    put(D2, 32'h0, 32'ha000, 16'h7, 16'h20, FE, 16'h0);
    wr(HEAD_BASE + 12'h024, D1);
    frag(32'h9005, 16'h10, 16'h30, 7'h49);
    frag(32'ha000, 16'h20, 16'h30, 7'h29);
    poll(CP_BASE + 12'h024, D2, "cp_rx1");
    chk("d1_flags", desc_mem_i.m[D1 / 4 + 3], {FS | FC, 16'h30});
    chk("d2_flags", desc_mem_i.m[D2 / 4 + 3], {FE | FQ, 16'h0});
    chk("d1_link", desc_mem_i.m[D1 / 4], D2);
    repeat (3) @(posedge hclk);
    rd(RX_RAW_OFF, 32'h2, "rx_raw");
    chk("rx_irq_off", {31'h0, rx_irq}, 32'h0);
    wr(RX_EN_SET_OFF, 32'h2);
    chk("rx_irq_on", {31'h0, rx_irq}, 32'h1);
    rd(RX_MASKED_OFF, 32'h2, "rx_masked");
    wr(RX_EN_CLR_OFF, 32'h2);
    chk("rx_irq_cleared", {31'h0, rx_irq}, 32'h0);
    rd(RX_EN_SET_OFF, 32'h0, "rx_enables");
    wr(RX_EN_SET_OFF, 32'h2);
    wr(CP_BASE + 12'h024, D2);
    chk("rx_irq_ack", {31'h0, rx_irq}, 32'h0);
    $display("test fragments done");
    put(D3, 32'h0, 32'hb000, 16'h0, 16'h8, FS | FE | FO, 16'h8);
    put(D4, 32'h0, 32'hc000, 16'h2, 16'h4, FS | FE | FO, 16'h4);
    wr(TX_EN_SET_OFF, 32'h2);
    bus(1'h1, HEAD_BASE + 12'h004, D3);
    desc_mem_i.m[D3 / 4] = D4;
    frag(32'hb000, 16'h8, 16'h8, 7'h71);
    frag(32'hc002, 16'h4, 16'h4, 7'h71);
    poll(CP_BASE + 12'h004, D4, "cp_tx1");
    chk("d3_flags", desc_mem_i.m[D3 / 4 + 3], {FS | FE, 16'h8});
    chk("d4_flags", desc_mem_i.m[D4 / 4 + 3], {FS | FE | FQ, 16'h4});
    rd(TX_MASKED_OFF, 32'h2, "tx_masked");
    wr(TX_EN_CLR_OFF, 32'h3);
    chk("tx_irq_cleared", {31'h0, tx_irq}, 32'h0);
    rd(TX_EN_SET_OFF, 32'h0, "tx_enables");
    rd(TX_RAW_OFF, 32'h2, "tx_raw_unmasked");
    wr(TX_EN_SET_OFF, 32'h2);
    chk("tx_irq_back", {31'h0, tx_irq}, 32'h1);
    wr(CP_BASE + 12'h004, D4);
    chk("tx_irq_ack1", {31'h0, tx_irq}, 32'h0);
    $display("test link patch done");
    put(D0, 32'h0, 32'h8000, 16'h0, 16'h10, FS | FE, 16'h10);
    wr(HEAD_BASE + 12'h008, D0);
    repeat (20) @(posedge hclk);
    chk("no_frag", {31'h0, frag_valid}, 32'h0);
    rd(HEAD_BASE + 12'h008, 32'h0, "head_halt");
    rd(CP_BASE + 12'h008, 32'h0, "cp_halt");
    chk("unowned_flags", desc_mem_i.m[D0 / 4 + 3], {FS | FE, 16'h10});
    $display("test unowned packet done");
    results;
  end
endmodule // desc_queue_dma_tb
